//--- design/map_register_file.v
// Flip-flop array of page mapping registers with one write and two reads.
// Assumes the caller only writes indices below the entry count.
`timescale 1ns/1ps
`include "shadow_ems_defs.vh"

module map_register_file #(
    parameter ENTRIES = 36,
    parameter WIDTH = 10
) (
    input wire clk_sys_in,
    input wire rst_n_in,
    input wire wr_lo_in,
    input wire wr_hi_in,
    input wire [5:0] wr_idx_in,
    input wire [WIDTH-1:0] wr_data_in,
    input wire [5:0] rd_idx_in,
    output wire [WIDTH-1:0] rd_data_out,
    input wire [5:0] lk_idx_in,
    output wire [WIDTH-1:0] lk_data_out
);

    reg [WIDTH-1:0] page_q [0:ENTRIES-1];

    // ==========================================
    // Storage
    genvar i;
    generate
        for (i = 0; i < ENTRIES; i = i + 1) begin : g_page
            // One mapping register, low byte and top bits written apart
            always @(posedge clk_sys_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    page_q[i] <= {WIDTH{1'b0}};
                end else if ({26'h0000000, wr_idx_in} == i) begin
                    if (wr_lo_in) begin
                        page_q[i][7:0] <= wr_data_in[7:0];
                    end
                    if (wr_hi_in) begin
                        page_q[i][WIDTH-1:8] <= wr_data_in[WIDTH-1:8];
                    end
                end
            end
        end
    endgenerate

    // ==========================================
    // Read ports, out-of-range reads give all ones
    assign rd_data_out = ({26'h0000000, rd_idx_in} < ENTRIES) ?
        page_q[rd_idx_in] : {WIDTH{1'b1}};
    assign lk_data_out = ({26'h0000000, lk_idx_in} < ENTRIES) ?
        page_q[lk_idx_in] : {WIDTH{1'b1}};

endmodule

//--- design/segment_router.v
// Turns one segment access code and access direction into a target.
// Assumes the caller has already picked the code for the addressed segment.
`timescale 1ns/1ps
`include "shadow_ems_defs.vh"

module segment_router (
    input wire [1:0] code_in,
    input wire rom_seg_in,
    input wire write_in,
    output reg to_dram_out,
    output reg to_slot_out,
    output reg to_rom_out
);

    // ==========================================
    // Routing table
    // Targets for the current access
    always @* begin
        to_dram_out = 1'b0;
        to_slot_out = 1'b0;
        to_rom_out = 1'b0;
        case (code_in)
            `ACC_SLOT: begin
                to_rom_out = rom_seg_in;
                to_slot_out = ~rom_seg_in;
            end
            `ACC_SETUP: begin
                if (write_in) begin
                    to_dram_out = 1'b1;
                end else begin
                    to_rom_out = rom_seg_in;
                    to_slot_out = ~rom_seg_in;
                end
            end
            `ACC_SHADOW: begin
                to_dram_out = ~write_in;
                to_slot_out = write_in;
            end
            `ACC_DRAM: begin
                to_dram_out = 1'b1;
            end
            default: begin
                to_slot_out = 1'b1;
            end
        endcase
    end

endmodule

//--- design/shadow_ems_defs.vh
// Constants for the upper-memory shadow control and page mapper.
// Assumes inclusion by bare name from the design files only.
`ifndef SHADOW_EMS_DEFS_VH
`define SHADOW_EMS_DEFS_VH

// ==========================================
// I/O port addresses
`define IO_MAP_INDEX 8'he8
`define IO_MAP_DATA_LO 8'hea
`define IO_MAP_DATA_HI 8'heb
`define IO_CFG_INDEX 8'hec
`define IO_CFG_DATA 8'hed

// ==========================================
// Indexed configuration register numbers
`define CFG_AB_ACCESS 8'h0e
`define CFG_C_ACCESS 8'h0f
`define CFG_D_ACCESS 8'h10
`define CFG_EF_ACCESS 8'h11
`define CFG_ACCESS_RESET 8'h00

// ==========================================
// Access codes per segment
`define ACC_SLOT 2'h0
`define ACC_SETUP 2'h1
`define ACC_SHADOW 2'h2
`define ACC_DRAM 2'h3

// ==========================================
// Mapping register numbering and index port fields
`define MAP_COUNT 6'h24
`define MAP_LAST 6'h23
`define MAP_BACKFILL_BASE 6'h0c
`define MAP_BACKFILL_BIAS 6'h04
`define IDX_NUM_MSB 5
`define IDX_AUTOINC_BIT 6
`define FILL_ONES_6 6'h3f
`define FILL_ONES_8 8'hff

// ==========================================
// Address field positions and 64K segment numbers
`define SEG_A 4'ha
`define SEG_B 4'hb
`define SEG_C 4'hc
`define SEG_D 4'hd
`define SEG_E 4'he
`define SEG_F 4'hf
`define BLK_LOW_FIRST 6'h10
`define BLK_LOW_LAST 6'h27
`define BLK_MSB 19
`define BLK_LSB 14
`define SEG_MSB 19
`define SEG_LSB 16
`define HIGH_MSB 23
`define HIGH_LSB 20
`define HIGH_ZERO 4'h0

`endif

//--- design/shadow_ram_and_ems_mapper.v
// Upper-memory shadow control and expanded-memory page translation.
// Assumes I/O and memory strobes are one-cycle pulses synchronous to clk_sys_in.
//
// Notes on behaviour
// - Each 16K C/D segment and 32K A/B/E/F segment has a two-bit code.
// - Code 00 sends reads and writes to slot bus, or ROM select in ROM space.
// - Code 01 in E/F: reads select on-board ROM, writes go to DRAM.
// - Code 01 in C/D: reads come from slot bus, writes go to DRAM.
// - Code 10: reads from DRAM, writes to slot bus.
// - Code 11: reads and writes both to DRAM.
// - Every segment code is decoded on its own.
// - With 384K remap selected, all shadow codes are ignored.
// - Thirty-six mapping registers, twelve page and twenty-four backfill.
// - A mapped enabled window gets its A23-A14 from its register.
// - Indices 0-B are page registers, 0C-23 are backfill registers.
// - Index port bits D0-D5 choose the mapping register.
// - Index port bit D6 turns auto-advance on or off.
// - EAh holds A21-A14, EBh A23-A22, word access at EAh reaches all.
// - With auto-advance, any EBh access steps the register number.
// - Unused data bits and index bit D7 read as one.
`timescale 1ns/1ps
`include "shadow_ems_defs.vh"

module shadow_ram_and_ems_mapper #(
    parameter MAP_ENTRIES = 36,
    parameter MAP_WIDTH = 10
) (
    input wire clk_sys_in,
    input wire rst_n_in,
    // I/O cycle port
    input wire io_rd_in,
    input wire io_wr_in,
    input wire io_word_in,
    input wire [7:0] io_addr_in,
    input wire [15:0] io_wdata_in,
    output reg [15:0] io_rdata_out,
    output reg io_rvalid_out,
    // Configuration levels from the rest of the controller
    input wire remap_384k_in,
    input wire ems_enable_in,
    input wire backfill_enable_in,
    input wire alternate_window_mapping_in,
    input wire [11:0] page_enable_in,
    // CPU memory access
    input wire mem_valid_in,
    input wire mem_write_in,
    input wire [23:0] mem_addr_in,
    output reg mem_valid_out,
    output reg [23:0] mem_addr_out,
    output reg mem_to_dram_out,
    output reg mem_to_slot_out,
    output reg rom_chip_select_n_out
);

    // ==========================================
    // State
    reg [7:0] shadow_ab_segment_access_q;
    reg [7:0] shadow_c_segment_access_q;
    reg [7:0] shadow_d_segment_access_q;
    reg [7:0] shadow_ef_segment_access_q;
    reg [7:0] cfg_index_q;
    reg [5:0] map_index_q;
    reg auto_inc_q;

    wire io_access;
    wire hit_index;
    wire hit_lo;
    wire hit_hi;
    wire hi_touch;
    wire map_wr_lo;
    wire map_wr_hi;
    wire [9:0] map_wr_data;
    wire [9:0] map_rd_data;
    wire [9:0] map_lk_data;
    reg [5:0] map_index_d;
    reg [7:0] cfg_rd;
    reg [15:0] io_rdata_d;
    reg [5:0] lk_idx;

    // ==========================================
    // I/O port decode
    assign io_access = io_rd_in | io_wr_in;
    assign hit_index = io_addr_in == `IO_MAP_INDEX;
    assign hit_lo = io_addr_in == `IO_MAP_DATA_LO;
    assign hit_hi = io_addr_in == `IO_MAP_DATA_HI;
    // word at EAh includes EBh half
    assign hi_touch = io_access & (hit_hi | (hit_lo & io_word_in));

    assign map_wr_lo = io_wr_in & hit_lo;
    assign map_wr_hi = io_wr_in & (hit_hi | (hit_lo & io_word_in));
    assign map_wr_data = hit_hi ? {io_wdata_in[1:0], 8'h00} : io_wdata_in[9:0];

    map_register_file #(
        .ENTRIES(MAP_ENTRIES),
        .WIDTH(MAP_WIDTH)
    ) u_maps (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .wr_lo_in(map_wr_lo),
        .wr_hi_in(map_wr_hi),
        .wr_idx_in(map_index_q),
        .wr_data_in(map_wr_data),
        .rd_idx_in(map_index_q),
        .rd_data_out(map_rd_data),
        .lk_idx_in(lk_idx),
        .lk_data_out(map_lk_data)
    );

    // ==========================================
    // Index port and auto-advance
    // Next selected mapping register number
    always @* begin
        map_index_d = map_index_q;
        if (io_wr_in && hit_index) begin
            map_index_d = io_wdata_in[`IDX_NUM_MSB:0];
        end else if (hi_touch && auto_inc_q) begin
            if (map_index_q >= `MAP_LAST) begin
                map_index_d = 6'h00;
            end else begin
                map_index_d = map_index_q + 6'h01;
            end
        end
    end

    // Index port registers
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            map_index_q <= 6'h00;
            auto_inc_q <= 1'b0;
        end else begin
            map_index_q <= map_index_d;
            if (io_wr_in && hit_index) begin
                auto_inc_q <= io_wdata_in[`IDX_AUTOINC_BIT];
            end
        end
    end

    // ==========================================
    // Indexed configuration registers
    // Shadow code registers and their index
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cfg_index_q <= 8'h00;
            // all segments start on code 00, slot bus or ROM select in E/F
            shadow_ab_segment_access_q <= `CFG_ACCESS_RESET;
            shadow_c_segment_access_q <= `CFG_ACCESS_RESET;
            shadow_d_segment_access_q <= `CFG_ACCESS_RESET;
            shadow_ef_segment_access_q <= `CFG_ACCESS_RESET;
        end else if (io_wr_in) begin
            if (io_addr_in == `IO_CFG_INDEX) begin
                cfg_index_q <= io_wdata_in[7:0];
            end else if (io_addr_in == `IO_CFG_DATA) begin
                case (cfg_index_q)
                    `CFG_AB_ACCESS: shadow_ab_segment_access_q <= io_wdata_in[7:0];
                    `CFG_C_ACCESS: shadow_c_segment_access_q <= io_wdata_in[7:0];
                    `CFG_D_ACCESS: shadow_d_segment_access_q <= io_wdata_in[7:0];
                    `CFG_EF_ACCESS: shadow_ef_segment_access_q <= io_wdata_in[7:0];
                    default: cfg_index_q <= cfg_index_q;
                endcase
            end
        end
    end

    // Selected configuration register value
    always @* begin
        case (cfg_index_q)
            `CFG_AB_ACCESS: cfg_rd = shadow_ab_segment_access_q;
            `CFG_C_ACCESS: cfg_rd = shadow_c_segment_access_q;
            `CFG_D_ACCESS: cfg_rd = shadow_d_segment_access_q;
            `CFG_EF_ACCESS: cfg_rd = shadow_ef_segment_access_q;
            default: cfg_rd = `FILL_ONES_8;
        endcase
    end

    // ==========================================
    // I/O read data
    // Read mux, unused bits read as ones
    always @* begin
        io_rdata_d = {`FILL_ONES_8, `FILL_ONES_8};
        case (io_addr_in)
            `IO_MAP_INDEX: begin
                io_rdata_d[7:0] = {1'b1, auto_inc_q, map_index_q};
            end
            `IO_MAP_DATA_LO: begin
                io_rdata_d[7:0] = map_rd_data[7:0];
                if (io_word_in) begin
                    io_rdata_d[15:8] = {`FILL_ONES_6, map_rd_data[9:8]};
                end
            end
            `IO_MAP_DATA_HI: begin
                io_rdata_d[7:0] = {`FILL_ONES_6, map_rd_data[9:8]};
            end
            `IO_CFG_INDEX: begin
                io_rdata_d[7:0] = cfg_index_q;
            end
            `IO_CFG_DATA: begin
                io_rdata_d[7:0] = cfg_rd;
            end
            default: begin
                io_rdata_d = {`FILL_ONES_8, `FILL_ONES_8};
            end
        endcase
    end

    // Registered read answer
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            io_rdata_out <= 16'hffff;
            io_rvalid_out <= 1'b0;
        end else begin
            io_rvalid_out <= io_rd_in;
            if (io_rd_in) begin
                io_rdata_out <= io_rdata_d;
            end
        end
    end

    // ==========================================
    // Memory window lookup
    wire [3:0] seg;
    wire [5:0] blk;
    wire low_mb;
    wire upper;
    wire rom_seg;
    reg lk_hit;
    reg [1:0] seg_code;
    wire [1:0] eff_code;
    wire to_dram;
    wire to_slot;
    wire to_rom;

    assign seg = mem_addr_in[`SEG_MSB:`SEG_LSB];
    assign blk = mem_addr_in[`BLK_MSB:`BLK_LSB];
    assign low_mb = mem_addr_in[`HIGH_MSB:`HIGH_LSB] == `HIGH_ZERO;
    assign upper = low_mb & (seg >= `SEG_A);
    assign rom_seg = (seg == `SEG_E) | (seg == `SEG_F);

    // Mapping register for the address, and whether it is enabled
    always @* begin
        lk_idx = 6'h00;
        lk_hit = 1'b0;
        if (low_mb) begin
            if (blk >= `BLK_LOW_FIRST && blk <= `BLK_LOW_LAST) begin
                lk_idx = blk - `MAP_BACKFILL_BIAS;
                lk_hit = backfill_enable_in;
            end else if (seg == `SEG_D) begin
                lk_idx = {2'b01, blk[1:0]};
                lk_hit = ems_enable_in & page_enable_in[lk_idx[3:0]];
            end else if (seg == (alternate_window_mapping_in ? `SEG_A : `SEG_C)) begin
                lk_idx = {2'b00, blk[1:0]};
                lk_hit = ems_enable_in & page_enable_in[lk_idx[3:0]];
            end else if (seg == (alternate_window_mapping_in ? `SEG_B : `SEG_E)) begin
                lk_idx = {2'b10, blk[1:0]};
                lk_hit = ems_enable_in & page_enable_in[lk_idx[3:0]];
            end
        end
    end

    // ==========================================
    // Shadow code selection
    // one code per segment
    always @* begin
        case (seg)
            `SEG_A, `SEG_B: seg_code = shadow_ab_segment_access_q[{seg[0], blk[1], 1'b0} +: 2];
            `SEG_C: seg_code = shadow_c_segment_access_q[{blk[1:0], 1'b0} +: 2];
            `SEG_D: seg_code = shadow_d_segment_access_q[{blk[1:0], 1'b0} +: 2];
            `SEG_E, `SEG_F: seg_code = shadow_ef_segment_access_q[{seg[0], blk[1], 1'b0} +: 2];
            default: seg_code = `ACC_SLOT;
        endcase
    end

    assign eff_code = remap_384k_in ? `ACC_SLOT : seg_code;

    segment_router u_route (
        .code_in(eff_code),
        .rom_seg_in(rom_seg),
        .write_in(mem_write_in),
        .to_dram_out(to_dram),
        .to_slot_out(to_slot),
        .to_rom_out(to_rom)
    );

    // ==========================================
    // Registered memory answer
    // Target and translated address for each access
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mem_valid_out <= 1'b0;
            mem_addr_out <= 24'h000000;
            mem_to_dram_out <= 1'b0;
            mem_to_slot_out <= 1'b0;
            rom_chip_select_n_out <= 1'b1;
        end else begin
            mem_valid_out <= mem_valid_in;
            if (!mem_valid_in) begin
                mem_to_dram_out <= 1'b0;
                mem_to_slot_out <= 1'b0;
                rom_chip_select_n_out <= 1'b1;
            end else if (lk_hit) begin
                mem_addr_out <= {map_lk_data, mem_addr_in[`BLK_LSB-1:0]};
                mem_to_dram_out <= 1'b1;
                mem_to_slot_out <= 1'b0;
                rom_chip_select_n_out <= 1'b1;
            end else if (upper) begin
                mem_addr_out <= mem_addr_in;
                mem_to_dram_out <= to_dram;
                mem_to_slot_out <= to_slot;
                rom_chip_select_n_out <= ~to_rom;
            end else begin
                mem_addr_out <= mem_addr_in;
                mem_to_dram_out <= 1'b1;
                mem_to_slot_out <= 1'b0;
                rom_chip_select_n_out <= 1'b1;
            end
        end
    end

endmodule

//--- test/cpu_model.sv
// CPU stand-in issuing single I/O and memory cycles.
// Assumes one task call at a time; drives on the falling edge.
`timescale 1ns/1ps
module cpu_model (
    input wire clk_sys_in,
    output logic io_rd_out,
    output logic io_wr_out,
    output logic io_word_out,
    output logic [7:0] io_addr_out,
    output logic [15:0] io_wdata_out,
    output logic mem_valid_out,
    output logic mem_write_out,
    output logic [23:0] mem_addr_out
);
    // Idle bus at time zero
    initial begin
        {io_rd_out, io_wr_out, io_word_out, mem_valid_out, mem_write_out} = 5'h00;
        io_addr_out = 8'h00;
        io_wdata_out = 16'h0000;
        mem_addr_out = 24'h000000;
    end
    // One I/O cycle, strobe held over a single rising edge
    task automatic bus(input logic rd, input logic [7:0] ad, input logic [15:0] d,
                       input logic w);
        @(negedge clk_sys_in);
        io_rd_out = rd;
        io_wr_out = !rd;
        io_word_out = w;
        io_addr_out = ad;
        io_wdata_out = d;
        @(negedge clk_sys_in);
        io_rd_out = 1'b0;
        io_wr_out = 1'b0;
        io_wdata_out = ~d; // Released data lines never show a stale copy
    endtask
    // One memory cycle
    task automatic mem(input logic [23:0] ad, input logic w);
        @(negedge clk_sys_in);
        mem_valid_out = 1'b1;
        mem_write_out = w;
        mem_addr_out = ad;
        @(negedge clk_sys_in);
        mem_valid_out = 1'b0;
        mem_addr_out = ~ad;
    endtask
endmodule

//--- test/shadow_ems_chk_sva.sv
// Port-level checker for the shadow control and page mapper.
// Assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/1ps
module shadow_ems_chk #(
    parameter MAP_ENTRIES = 36,
    parameter MAP_WIDTH = 10
) (
    input logic clk_sys_in,
    input logic rst_n_in,
    input logic io_rd_in,
    input logic io_wr_in,
    input logic io_word_in,
    input logic [7:0] io_addr_in,
    input logic [15:0] io_wdata_in,
    input logic [15:0] io_rdata_out,
    input logic io_rvalid_out,
    input logic remap_384k_in,
    input logic ems_enable_in,
    input logic backfill_enable_in,
    input logic alternate_window_mapping_in,
    input logic [11:0] page_enable_in,
    input logic mem_valid_in,
    input logic mem_write_in,
    input logic [23:0] mem_addr_in,
    input logic mem_valid_out,
    input logic [23:0] mem_addr_out,
    input logic mem_to_dram_out,
    input logic mem_to_slot_out,
    input logic rom_chip_select_n_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    // ====
    // I/O answers
    a_read_answer: assert property (io_rd_in |=> io_rvalid_out)
        else $error("read not answered");
    a_no_stray_answer: assert property (io_rvalid_out |-> $past(io_rd_in))
        else $error("answer without read");
    a_index_top_one: assert property (
        io_rvalid_out && $past(io_addr_in) == 8'he8 |-> io_rdata_out[7])
        else $error("index bit 7 not one");
    a_word_high_ones: assert property (
        io_rvalid_out && $past(io_addr_in) == 8'hea && $past(io_word_in)
        |-> io_rdata_out[15:10] == 6'h3f)
        else $error("unused data bits not one");
    // ====
    // Memory routing
    a_mem_offset_kept: assert property (mem_valid_in |=> mem_valid_out &&
        mem_addr_out[13:0] == $past(mem_addr_in[13:0]))
        else $error("window offset changed");
    a_one_target: assert property (mem_valid_out |->
        $onehot({mem_to_dram_out, mem_to_slot_out, !rom_chip_select_n_out}))
        else $error("not exactly one target");
    a_idle_targets: assert property (!mem_valid_out |-> !mem_to_dram_out &&
        !mem_to_slot_out && rom_chip_select_n_out)
        else $error("target while idle");
    a_remap_slot: assert property (mem_valid_in && remap_384k_in &&
        !ems_enable_in && mem_addr_in[23:17] == 7'h06 |=> mem_to_slot_out)
        else $error("shadow code used under remap");
    a_high_pass: assert property (mem_valid_in && mem_addr_in[23:20] != 4'h0
        |=> mem_to_dram_out && mem_addr_out == $past(mem_addr_in))
        else $error("high address not passed to dram");
endmodule
bind shadow_ram_and_ems_mapper shadow_ems_chk #(
    .MAP_ENTRIES(MAP_ENTRIES),
    .MAP_WIDTH(MAP_WIDTH)
) u_shadow_ems_chk (.*);

//--- test/tb.sv
// Self-checking bench for the shadow control and page mapper.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
module tb;
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic io_rd, io_wr, io_word, mem_valid, mem_write;
    logic io_rvalid, mvo, to_dram, to_slot, rom_n;
    logic [7:0] io_addr;
    logic [15:0] io_wdata, io_rdata;
    logic [23:0] mem_addr, maddr, a;
    logic remap = 1'b0, ems = 1'b0, bf = 1'b0, alt = 1'b0;
    logic [11:0] pen = 12'h000;
    logic [9:0] mr [36];
    logic [7:0] sh [4];
    logic [26:0] e;
    int num_errors = 0, cmp_count = 0, cycles = 0, i, k;
    always #4 clk_sys_in = ~clk_sys_in;
    shadow_ram_and_ems_mapper u_shadow_ram_and_ems_mapper (.clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in), .io_rd_in(io_rd), .io_wr_in(io_wr), .io_word_in(io_word),
        .io_addr_in(io_addr), .io_wdata_in(io_wdata), .io_rdata_out(io_rdata),
        .io_rvalid_out(io_rvalid), .remap_384k_in(remap), .ems_enable_in(ems),
        .backfill_enable_in(bf), .alternate_window_mapping_in(alt),
        .page_enable_in(pen), .mem_valid_in(mem_valid), .mem_write_in(mem_write),
        .mem_addr_in(mem_addr), .mem_valid_out(mvo), .mem_addr_out(maddr),
        .mem_to_dram_out(to_dram), .mem_to_slot_out(to_slot),
        .rom_chip_select_n_out(rom_n));
    cpu_model u_cpu_model (.clk_sys_in(clk_sys_in), .io_rd_out(io_rd), .io_wr_out(io_wr),
        .io_word_out(io_word), .io_addr_out(io_addr), .io_wdata_out(io_wdata),
        .mem_valid_out(mem_valid), .mem_write_out(mem_write), .mem_addr_out(mem_addr));
    // ====
    // Compare and verdict
    task automatic chk(input string n, input logic [23:0] s, input logic [23:0] x);
        cmp_count++;
        if (s !== x) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic conclude;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            conclude();
        end
    end
    // ====
    // Reference routing: {dram, slot, rom_n, address}
    function automatic logic [26:0] route(input logic [23:0] ad, input logic w);
        int b, ix, r, p;
        logic [1:0] c;
        b = ad[19:14];
        ix = -1;
        if (ad[23:20] == 4'h0) begin
            if (ems && !alt && b >= 'h30 && b <= 'h3b) ix = b - 'h30;
            if (ems && alt && b >= 'h28 && b <= 'h2b) ix = b - 'h28;
            if (ems && alt && b >= 'h2c && b <= 'h2f) ix = b - 'h24;
            if (ems && alt && b >= 'h34 && b <= 'h37) ix = b - 'h30;
            if (ix >= 0 && !pen[ix]) ix = -1;
            if (bf && b >= 'h10 && b <= 'h27) ix = b - 4;
        end
        if (ix >= 0) return {3'b101, mr[ix], ad[13:0]};
        if (ad[23:20] != 4'h0 || b < 'h28) return {3'b101, ad};
        r = (b < 'h30) ? 0 : (b < 'h34) ? 1 : (b < 'h38) ? 2 : 3;
        p = (r == 1 || r == 2) ? ad[15:14] : ad[16:15];
        c = remap ? 2'b00 : sh[r][2*p +: 2];
        if (c == 2'b11 || (c == 2'b01 && w) || (c == 2'b10 && !w)) return {3'b101, ad};
        if (c != 2'b10 && r == 3) return {3'b000, ad};
        return {3'b011, ad};
    endfunction
    // ====
    // Main sequence
    initial begin
        k = $urandom(50);
        repeat (12) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        rst_n_in = 1'b1;
        u_cpu_model.bus(1, 8'he8, 0, 0);
        chk("index", io_rdata[7:0], 8'h80);
        u_cpu_model.bus(1, 8'h80, 0, 1);
        chk("unmapped", io_rdata, 16'hffff);
        for (i = 0; i < 5; i++) begin
            u_cpu_model.bus(0, 8'hec, 8'h0d + i, 0);
            u_cpu_model.bus(1, 8'hed, 0, 0);
            chk("cfg_reset", io_rdata[7:0], i == 0 ? 8'hff : 8'h00);
        end
        u_cpu_model.bus(1, 8'hec, 0, 0);
        chk("cfg_index", io_rdata[7:0], 8'h11);
        // word fill with auto-advance and wrap
        u_cpu_model.bus(0, 8'he8, 16'h0062, 0);
        k = 34;
        for (i = 0; i < 36; i++) begin
            mr[k] = $urandom;
            u_cpu_model.bus(0, 8'hea, {6'h00, mr[k]}, 1);
            k = (k + 1) % 36;
        end
        u_cpu_model.bus(1, 8'he8, 0, 0);
        chk("index_wrap", io_rdata[7:0], 8'he2);
        for (i = 0; i < 36; i++) begin
            u_cpu_model.bus(1, 8'hea, 0, 1);
            chk("map_word", io_rdata, {6'h3f, mr[k]});
            k = (k + 1) % 36;
        end
        // byte halves of first backfill entry
        u_cpu_model.bus(0, 8'he8, 16'h000c, 0);
        mr[12] = $urandom;
        u_cpu_model.bus(0, 8'hea, mr[12][7:0], 0);
        u_cpu_model.bus(0, 8'heb, mr[12][9:8], 0);
        u_cpu_model.bus(1, 8'heb, 0, 0);
        chk("map_hi", io_rdata[7:0], {6'h3f, mr[12][9:8]});
        u_cpu_model.bus(1, 8'hea, 0, 0);
        chk("map_lo", io_rdata[7:0], mr[12][7:0]);
        u_cpu_model.bus(1, 8'he8, 0, 0);
        chk("index_hold", io_rdata[7:0], 8'h8c);
        // only the high port steps the number
        u_cpu_model.bus(0, 8'he8, 16'h004b, 0);
        u_cpu_model.bus(1, 8'hea, 0, 0);
        chk("map_lo", io_rdata[7:0], mr[11][7:0]);
        u_cpu_model.bus(1, 8'heb, 0, 0);
        u_cpu_model.bus(1, 8'he8, 0, 0);
        chk("index_step", io_rdata[7:0], 8'hcc);
        for (i = 1; i < 3; i++) begin
            u_cpu_model.bus(0, 8'hec, 8'h0f, 0);
            u_cpu_model.bus(0, 8'hed, 8'h55 * i, 0);
        end
        for (i = 0; i < 600; i++) begin
            if (i % 20 == 0) begin
                for (k = 0; k < 4; k++) begin
                    sh[k] = $urandom;
                    u_cpu_model.bus(0, 8'hec, 8'h0e + k, 0);
                    u_cpu_model.bus(0, 8'hed, sh[k], 0);
                end
            end
            @(negedge clk_sys_in);
            {remap, ems, bf, alt} = $urandom;
            pen = $urandom;
            a = $urandom;
            if (a[22:21] != 2'b00) a[23:20] = 4'h0;
            k = $urandom % 2;
            e = route(a, k[0]);
            u_cpu_model.mem(a, k[0]);
            chk("mem_target", {to_dram, to_slot, rom_n}, e[26:24]);
            chk("mem_addr", maddr, e[23:0]);
        end
        conclude();
    end
endmodule
